// ### core/bus_sync_pkg.sv
`default_nettype none
package bus_sync_pkg;
   // ---------------------------------------------------------------
   // instruction, region and width codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_LOAD, OP_STORE, OP_BARRIER,
      OP_INT_EN, OP_INT_DIS, OP_COP0_WR, OP_STANDBY
   } op_kind_e;
   typedef enum logic [1:0] {REG_ROM, REG_RAM, REG_SYSBUS, REG_PERBUS} region_e;
   typedef enum logic [1:0] {W_BYTE, W_HALF, W_WORD} width_e;

   // ---------------------------------------------------------------
   // write buffer geometry
   // ---------------------------------------------------------------
   localparam int WB_DEPTH = 4;
   localparam int WB_PTR_W = 2;
   localparam int WB_ENTRY_W = 4;
   localparam logic [WB_PTR_W-1:0] WB_PTR_ONE = 2'h1;
   localparam logic [WB_PTR_W:0] WB_FULL_CNT = 3'h4;

   // ---------------------------------------------------------------
   // access times (system clocks, peripheral bus in its own ticks)
   // ---------------------------------------------------------------
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] ROM_OPERAND_CLK = 3'h2;
   localparam logic [CNT_W-1:0] ROM_FETCH_CLK = 3'h1;
   localparam logic [CNT_W-1:0] RAM_CLK = 3'h1;
   localparam logic [CNT_W-1:0] SYSBUS_CPU_MIN_CLK = 3'h3;
   localparam logic [CNT_W-1:0] SYSBUS_DMA_CLK = 3'h4;
   localparam logic [CNT_W-1:0] PERBUS_MIN_TICKS = 3'h4;

   // ---------------------------------------------------------------
   // system control coprocessor status
   // ---------------------------------------------------------------
   localparam int COP0_W = 8;
   localparam int COP0_IE_BIT = 0;
   localparam logic [COP0_W-1:0] COP0_RESET = 8'h00;
endpackage : bus_sync_pkg
`default_nettype wire

// ### core/wbuf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module wbuf_fifo (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [bus_sync_pkg::WB_ENTRY_W-1:0] push_data,
   input wire logic pop,
   output logic [bus_sync_pkg::WB_ENTRY_W-1:0] pop_data,
   output logic full,
   output logic empty
);
   import bus_sync_pkg::*;

   logic [WB_ENTRY_W-1:0] mem_q [WB_DEPTH];
   logic [WB_PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [WB_PTR_W:0] cnt_q, cnt_d;
   logic do_push, do_pop;

   // ---------------------------------------------------------------
   // pointers and fill count
   // ---------------------------------------------------------------
   assign full = (cnt_q == WB_FULL_CNT);
   assign empty = (cnt_q == '0);
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;
   assign pop_data = mem_q[rd_q];

   // next pointer values
   always_comb begin
      wr_d = do_push ? wr_q + WB_PTR_ONE : wr_q;
      rd_d = do_pop ? rd_q + WB_PTR_ONE : rd_q;
      cnt_d = cnt_q + {2'h0, do_push} - {2'h0, do_pop};
   end

   // pointer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // entry storage, no reset needed: read only when counted
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_data;
      end
   end
endmodule : wbuf_fifo
`default_nettype wire

// ### core/bus_sync_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - a load does not stall the pipeline unless one is already pending
// - barrier holds until cpu bus work done; a dma cycle does not hold it
// - rom operand 2, fetch 1 (byte fetch 2), ram 1
// - system bus cpu 3-4, dma 4 clocks
// - peripheral bus 4-5 peripheral clocks
// - interrupt enable effective two clocks later
// - disable immediate, status two clocks later
// - cop0 write two clocks, disable immediate
// - standby entered two clocks after instruction
// - state instructions never wait for bus
// - four-entry write buffer, loads wait empty
module bus_sync_ctrl (
   input wire logic clk,
   input wire logic rstn,
   input wire logic op_valid,
   input wire bus_sync_pkg::op_kind_e op_kind,
   input wire bus_sync_pkg::region_e op_region,
   input wire bus_sync_pkg::width_e op_width,
   input wire logic [bus_sync_pkg::COP0_W-1:0] op_wdata,
   output logic op_stall,
   input wire logic fetch_req,
   input wire bus_sync_pkg::region_e fetch_region,
   input wire bus_sync_pkg::width_e fetch_width,
   output logic fetch_ready,
   output logic fetch_done,
   input wire logic dma_req,
   input wire bus_sync_pkg::region_e dma_region,
   output logic dma_ack,
   output logic dma_done,
   input wire logic sysbus_wait,
   input wire logic perbus_wait,
   input wire logic peripheral_bus_clock_tick,
   input wire logic wake,
   output logic load_done,
   output logic store_done,
   output logic int_allowed,
   output logic [bus_sync_pkg::COP0_W-1:0] cop0_status,
   output logic standby_mode
);
   import bus_sync_pkg::*;

   typedef enum logic [1:0] {SRC_LOAD, SRC_STORE, SRC_DMA} src_e;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // access time by target, initiator and width
   function automatic logic [CNT_W-1:0] lat_f(region_e r, width_e w, logic fetch,
                                              logic dma, logic slow);
      logic [CNT_W-1:0] l;
      l = RAM_CLK;
      case (r)
         REG_ROM: l = (fetch && w != W_BYTE) ? ROM_FETCH_CLK : ROM_OPERAND_CLK;
         REG_RAM: l = RAM_CLK;
         REG_SYSBUS: l = dma ? SYSBUS_DMA_CLK : SYSBUS_CPU_MIN_CLK + {2'h0, slow};
         default: l = PERBUS_MIN_TICKS + {2'h0, slow};
      endcase
      return l;
   endfunction : lat_f

   // ---------------------------------------------------------------
   // issue decode and stall
   // ---------------------------------------------------------------
   logic busy_q, busy_d, load_pend_q, load_pend_d, cpu_idle;
   logic wb_full, wb_empty, wb_pop, wb_push, load_accept;
   logic ei_now, di_now, cop0_now, stby_now, block_now;
   logic [WB_ENTRY_W-1:0] wb_head;
   src_e src_q, src_d;

   assign ei_now = op_valid && op_kind == OP_INT_EN;
   assign di_now = op_valid && op_kind == OP_INT_DIS;
   assign cop0_now = op_valid && op_kind == OP_COP0_WR;
   assign stby_now = op_valid && op_kind == OP_STANDBY;
   assign cpu_idle = ~(busy_q && src_q != SRC_DMA) & wb_empty & ~load_pend_q;

   // only a second load, a full buffer or a busy barrier stall issue
   always_comb begin
      op_stall = 1'b0;
      if (op_valid) begin
         case (op_kind)
            OP_LOAD: op_stall = load_pend_q;
            OP_STORE: op_stall = wb_full;
            OP_BARRIER: op_stall = ~cpu_idle;
            default: op_stall = 1'b0;
         endcase
      end
   end
   assign load_accept = op_valid && op_kind == OP_LOAD && !load_pend_q;
   assign wb_push = op_valid && op_kind == OP_STORE && !wb_full;

   // ---------------------------------------------------------------
   // write buffer
   // ---------------------------------------------------------------
   wbuf_fifo u_wbuf (
      .clk(clk),
      .rst_n(rst_n),
      .push(wb_push),
      .push_data({op_region, op_width}),
      .pop(wb_pop),
      .pop_data(wb_head),
      .full(wb_full),
      .empty(wb_empty)
   );

   // ---------------------------------------------------------------
   // bus cycle engine, runs apart from the pipeline
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q, cnt_d;
   region_e rgn_q, rgn_d, start_rgn, load_rgn_q, load_rgn_d;
   width_e start_w, load_w_q, load_w_d;
   src_e start_src;
   logic start, fin;

   // pick dma, then buffered stores, then a pending load
   always_comb begin
      busy_d = busy_q;
      cnt_d = cnt_q;
      src_d = src_q;
      rgn_d = rgn_q;
      start = 1'b0;
      fin = 1'b0;
      wb_pop = 1'b0;
      dma_ack = 1'b0;
      start_src = SRC_LOAD;
      start_rgn = load_rgn_q;
      start_w = load_w_q;
      if (busy_q) begin
         if (rgn_q != REG_PERBUS || peripheral_bus_clock_tick) begin
            if (cnt_q == CNT_ONE) begin
               fin = 1'b1;
               busy_d = 1'b0;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
      end else if (dma_req) begin
         start = 1'b1;
         dma_ack = 1'b1;
         start_src = SRC_DMA;
         start_rgn = dma_region;
         start_w = W_WORD;
      end else if (!wb_empty) begin
         start = 1'b1;
         wb_pop = 1'b1;
         start_src = SRC_STORE;
         start_rgn = region_e'(wb_head[3:2]);
         start_w = width_e'(wb_head[1:0]);
      end else if (load_pend_q) begin
         start = 1'b1;
      end
      if (start) begin
         busy_d = 1'b1;
         src_d = start_src;
         rgn_d = start_rgn;
         cnt_d = lat_f(start_rgn, start_w, 1'b0, start_src == SRC_DMA,
                       start_rgn == REG_SYSBUS ? sysbus_wait : perbus_wait);
      end
   end

   // non-blocking load slot
   always_comb begin
      load_pend_d = load_pend_q;
      load_rgn_d = load_rgn_q;
      load_w_d = load_w_q;
      if (start && start_src == SRC_LOAD) begin
         load_pend_d = 1'b0;
      end
      if (load_accept) begin
         load_pend_d = 1'b1;
         load_rgn_d = op_region;
         load_w_d = op_width;
      end
   end

   // engine registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
         src_q <= SRC_LOAD;
         rgn_q <= REG_RAM;
         load_pend_q <= 1'b0;
         load_rgn_q <= REG_RAM;
         load_w_q <= W_WORD;
      end else begin
         busy_q <= busy_d;
         cnt_q <= cnt_d;
         src_q <= src_d;
         rgn_q <= rgn_d;
         load_pend_q <= load_pend_d;
         load_rgn_q <= load_rgn_d;
         load_w_q <= load_w_d;
      end
   end
   assign load_done = fin && src_q == SRC_LOAD;
   assign store_done = fin && src_q == SRC_STORE;
   assign dma_done = fin && src_q == SRC_DMA;

   // ---------------------------------------------------------------
   // instruction fetch timer
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] fcnt_q, fcnt_d;
   assign fetch_ready = (fcnt_q == '0);
   assign fetch_done = (fcnt_q == CNT_ONE);
   always_comb begin
      fcnt_d = fcnt_q;
      if (!fetch_ready) begin
         fcnt_d = fcnt_q - CNT_ONE;
      end else if (fetch_req) begin
         fcnt_d = lat_f(fetch_region, fetch_width, 1'b1, 1'b0, 1'b0);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fcnt_q <= '0;
      end else begin
         fcnt_q <= fcnt_d;
      end
   end

   // ---------------------------------------------------------------
   // interrupt enable, cop0 status and standby
   // ---------------------------------------------------------------
   logic pend_ei_q, pend_di_q, pend_cop0_q, pend_stby_q, ie_eff_q, ie_eff_d, stby_d;
   logic [COP0_W-1:0] pend_data_q, cop0_d;
   assign block_now = di_now | (cop0_now & ~op_wdata[COP0_IE_BIT]);
   assign int_allowed = ie_eff_q & ~block_now;

   // one pending stage plus the state register gives two clocks
   always_comb begin
      ie_eff_d = ie_eff_q;
      cop0_d = cop0_status;
      stby_d = standby_mode;
      if (pend_ei_q) begin
         ie_eff_d = 1'b1;
         cop0_d[COP0_IE_BIT] = 1'b1;
      end
      if (pend_di_q) begin
         cop0_d[COP0_IE_BIT] = 1'b0;
      end
      if (pend_cop0_q) begin
         cop0_d = pend_data_q;
         ie_eff_d = pend_data_q[COP0_IE_BIT];
      end
      if (block_now) begin
         ie_eff_d = 1'b0;
      end
      if (wake) begin
         stby_d = 1'b0;
      end
      if (pend_stby_q) begin
         stby_d = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_ei_q <= 1'b0;
         pend_di_q <= 1'b0;
         pend_cop0_q <= 1'b0;
         pend_stby_q <= 1'b0;
         pend_data_q <= COP0_RESET;
         ie_eff_q <= 1'b0;
         cop0_status <= COP0_RESET;
         standby_mode <= 1'b0;
      end else begin
         pend_ei_q <= ei_now;
         pend_di_q <= di_now;
         pend_cop0_q <= cop0_now;
         pend_stby_q <= stby_now;
         pend_data_q <= op_wdata;
         ie_eff_q <= ie_eff_d;
         cop0_status <= cop0_d;
         standby_mode <= stby_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] ticks_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks_q <= '0;
      end else if (start) begin
         ticks_q <= '0;
      end else if (busy_q && peripheral_bus_clock_tick && !fin) begin
         ticks_q <= ticks_q + CNT_ONE;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_nonblock; op_valid && op_kind == OP_LOAD && !load_pend_q |-> !op_stall; endproperty
   a_nonblock: assert property (p_nonblock) else $error("first load stalled");
   property p_barrier; op_valid && op_kind == OP_BARRIER && !cpu_idle |-> op_stall; endproperty
   a_barrier: assert property (p_barrier) else $error("barrier passed busy bus");
   property p_rom; start && start_rgn == REG_ROM |=> !fin ##1 fin; endproperty
   a_rom: assert property (p_rom) else $error("rom operand not two clocks");
   property p_ram; start && start_rgn == REG_RAM |=> fin; endproperty
   a_ram: assert property (p_ram) else $error("ram not one clock");
   property p_fetch;
      fetch_req && fetch_ready && fetch_region == REG_ROM && fetch_width != W_BYTE |=> fetch_done;
   endproperty
   a_fetch: assert property (p_fetch) else $error("rom fetch not one clock");
   property p_sys;
      start && start_rgn == REG_SYSBUS && start_src != SRC_DMA |=> !fin [*2] ##[1:2] fin;
   endproperty
   a_sys: assert property (p_sys) else $error("cpu system bus not 3 to 4");
   property p_sysdma;
      start && start_rgn == REG_SYSBUS && start_src == SRC_DMA |=> !fin [*3] ##1 fin;
   endproperty
   a_sysdma: assert property (p_sysdma) else $error("dma system bus not 4");
   property p_per;
      fin && rgn_q == REG_PERBUS |-> peripheral_bus_clock_tick && ticks_q inside {3, 4};
   endproperty
   a_per: assert property (p_per) else $error("peripheral bus not 4 to 5 ticks");
   property p_ei; ei_now ##1 !block_now |=> ie_eff_q; endproperty
   a_ei: assert property (p_ei) else $error("enable late");
   property p_di;
      di_now |-> !int_allowed ##1 !ie_eff_q ##1 !cop0_status[COP0_IE_BIT];
   endproperty
   a_di: assert property (p_di) else $error("disable timing wrong");
   property p_cop0; cop0_now |-> ##2 cop0_status == $past(op_wdata, 2); endproperty
   a_cop0: assert property (p_cop0) else $error("cop0 write not two clocks");
   // neither early nor late: still off one clock later, on the second
   property p_stby;
      stby_now && !standby_mode && !pend_stby_q |=> !standby_mode ##1 standby_mode;
   endproperty
   a_stby: assert property (p_stby) else $error("standby not two clocks");
   property p_nowait; op_valid && op_kind inside {OP_INT_EN, OP_INT_DIS, OP_COP0_WR, OP_STANDBY}
      |-> !op_stall; endproperty
   a_nowait: assert property (p_nowait) else $error("state instruction waited");
   property p_order; start && start_src == SRC_LOAD |-> wb_empty; endproperty
   a_order: assert property (p_order) else $error("load passed buffered store");
   property p_free; op_valid && op_kind == OP_BARRIER && cpu_idle |-> !op_stall; endproperty
   a_free: assert property (p_free) else $error("idle barrier stalled");

   c_barrier: cover property (op_stall && op_kind == OP_BARRIER ##[1:40] !op_stall);
   c_load_after_store: cover property (wb_full ##[1:60] start && start_src == SRC_LOAD);
   c_standby: cover property (stby_now ##2 standby_mode);
   c_per: cover property (fin && rgn_q == REG_PERBUS);
endmodule : bus_sync_ctrl
`default_nettype wire

// ### test/far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic dma_go,
   input wire bus_sync_pkg::region_e dma_go_region,
   input wire logic dma_ack,
   output logic dma_req,
   output bus_sync_pkg::region_e dma_region,
   output logic peripheral_bus_clock_tick
);
   import bus_sync_pkg::*;

   logic [2:0] tick_cnt_q;
   logic ack_seen_q;

   // -----------------------------------------------------------
   // peripheral bus clock, one tick per seven system clocks
   // -----------------------------------------------------------
   always @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= 3'h0;
      end else begin
         tick_cnt_q <= (tick_cnt_q == 3'h6) ? 3'h0 : tick_cnt_q + 3'h1;
      end
   end
   assign peripheral_bus_clock_tick = (tick_cnt_q == 3'h6);

   // -----------------------------------------------------------
   // dma requester: holds its request until the ack edge
   // -----------------------------------------------------------
   always @(posedge clk) begin
      ack_seen_q <= dma_req & dma_ack;
   end
   always @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         dma_req <= 1'b0;
         dma_region <= REG_RAM;
      end else if (dma_req && ack_seen_q) begin
         dma_req <= 1'b0;
         dma_region <= region_e'(~dma_region); // released target is not kept
      end else if (dma_go && !dma_req) begin
         dma_req <= 1'b1;
         dma_region <= dma_go_region;
      end
   end
endmodule : far_side_model
`default_nettype wire

// ### test/bus_cycle_sync_pipeline_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_sync_pipeline_control_tb_top;
   import bus_sync_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, fetch_req = 1'b0, dma_go = 1'b0;
   logic sysbus_wait = 1'b0, perbus_wait = 1'b0, wake = 1'b0, ia_take;
   op_kind_e op_kind = OP_NONE;
   region_e op_region = REG_RAM, fetch_region = REG_ROM, dma_go_region = REG_RAM, dma_region;
   width_e op_width = W_WORD, fetch_width = W_WORD;
   logic [7:0] op_wdata = 8'h00, cop0_status;
   logic op_stall, fetch_ready, fetch_done, dma_req, dma_ack, dma_done, tick;
   logic load_done, store_done, int_allowed, standby_mode;
   int cyc = 0, t_iss, t_ack, sd_cnt = 0, tk_cnt = 0, n_mismatch = 0, checks_done = 0;
   int st, t, s0, k0;

   // -----------------------------------------------------------
   // clock, cycle index and event counters
   // -----------------------------------------------------------
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (dma_ack) t_ack = cyc;
      if (store_done) sd_cnt = sd_cnt + 1;
      if (tick) tk_cnt = tk_cnt + 1;
      cyc = cyc + 1;
   end

   bus_sync_ctrl u_bus_sync_ctrl (.clk(clk), .rstn(rstn), .op_valid(op_valid),
      .op_kind(op_kind), .op_region(op_region), .op_width(op_width), .op_wdata(op_wdata),
      .op_stall(op_stall), .fetch_req(fetch_req), .fetch_region(fetch_region),
      .fetch_width(fetch_width), .fetch_ready(fetch_ready), .fetch_done(fetch_done),
      .dma_req(dma_req), .dma_region(dma_region), .dma_ack(dma_ack), .dma_done(dma_done),
      .sysbus_wait(sysbus_wait), .perbus_wait(perbus_wait),
      .peripheral_bus_clock_tick(tick), .wake(wake), .load_done(load_done),
      .store_done(store_done), .int_allowed(int_allowed), .cop0_status(cop0_status),
      .standby_mode(standby_mode));
   far_side_model u_far_side_model (.clk(clk), .rstn(rstn), .dma_go(dma_go),
      .dma_go_region(dma_go_region), .dma_ack(dma_ack), .dma_req(dma_req),
      .dma_region(dma_region), .peripheral_bus_clock_tick(tick));

   // -----------------------------------------------------------
   // expectations, comparison and verdict
   // -----------------------------------------------------------
   function automatic int exp_lat(region_e r, width_e w, logic wt, logic fe, logic dm);
      case (r)
         REG_ROM: exp_lat = (fe && w != W_BYTE) ? 1 : 2;
         REG_RAM: exp_lat = 1;
         default: exp_lat = dm ? 4 : (fe ? 3 : 3 + int'(wt));
      endcase
   endfunction : exp_lat
   function automatic logic pick(int s);
      case (s)
         0: pick = load_done;
         1: pick = store_done;
         2: pick = fetch_done;
         default: pick = dma_done;
      endcase
   endfunction : pick
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask : chk
   task automatic give_verdict;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // -----------------------------------------------------------
   // instruction issue, held while stalled, and done wait
   // -----------------------------------------------------------
   task automatic issue(input op_kind_e k, input region_e r, input width_e w,
                        input logic [7:0] d);
      @(negedge clk);
      op_valid = 1'b1;
      op_kind = k;
      op_region = r;
      op_width = w;
      op_wdata = d;
      st = 0;
      #1;
      while (op_stall && st < 400) begin
         @(negedge clk);
         #1;
         st++;
      end
      t_iss = cyc;
      ia_take = int_allowed;
      @(negedge clk);
      op_valid = 1'b0;
      op_kind = OP_NONE;
      #1;
   endtask : issue
   task automatic wait_done(input int s);
      int n;
      n = 0;
      while (pick(s) !== 1'b1 && n < 400) begin
         @(negedge clk);
         #1;
         n++;
      end
      t = cyc;
   endtask : wait_done
   task automatic step;
      @(negedge clk);
      #1;
   endtask : step

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      region_e r;
      width_e w;
      logic ld;
      void'($urandom(26));
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (5) @(negedge clk);
      chk(cop0_status, 8'h00);
      chk({int_allowed, standby_mode, fetch_ready}, 3'h1);
      // random isolated accesses, each followed by an idle barrier
      for (int i = 0; i < 16; i++) begin
         r = region_e'($urandom_range(2, 0));
         w = width_e'($urandom_range(2, 0));
         ld = 1'($urandom_range(1, 0));
         @(negedge clk);
         sysbus_wait = 1'($urandom_range(1, 0));
         issue(ld ? OP_LOAD : OP_STORE, r, w, 8'h00);
         chk(st, 0);
         wait_done(ld ? 0 : 1);
         chk(t - t_iss, 1 + exp_lat(r, w, sysbus_wait, 1'b0, 1'b0));
         issue(OP_BARRIER, r, w, 8'h00);
         chk(st, 0);
         @(negedge clk);
         fetch_req = 1'b1;
         fetch_region = r;
         fetch_width = w;
         #1;
         while (!fetch_ready) step;
         s0 = cyc;
         @(negedge clk);
         fetch_req = 1'b0;
         #1;
         wait_done(2);
         chk(t - s0, exp_lat(r, w, 1'b0, 1'b1, 1'b0));
      end
      // slow store then barrier: barrier waits for the store
      sysbus_wait = 1'b1;
      s0 = sd_cnt;
      issue(OP_STORE, REG_SYSBUS, W_HALF, 8'h00);
      issue(OP_BARRIER, REG_RAM, W_WORD, 8'h00);
      chk(st != 0, 1'b1);
      chk(sd_cnt - s0, 1);
      // dma timing on the fast bus and ram
      for (int i = 0; i < 2; i++) begin
         // non-blocking: the model also acts on the falling edge
         @(negedge clk);
         dma_go <= 1'b1;
         dma_go_region <= i ? REG_RAM : REG_SYSBUS;
         @(negedge clk);
         dma_go <= 1'b0;
         #1;
         wait_done(3);
         chk(t - t_ack, exp_lat(dma_go_region, W_WORD, 1'b0, 1'b0, 1'b1));
         step;
      end
      // peripheral bus stores, four then five ticks
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         perbus_wait = 1'(i);
         issue(OP_STORE, REG_PERBUS, W_BYTE, 8'h00);
         step;
         k0 = tk_cnt;
         wait_done(1);
         chk(tk_cnt - k0 + int'(tick), 4 + i);
         step;
      end
      // fill the write buffer, then state instructions behind it
      s0 = sd_cnt;
      for (int i = 0; i < 6; i++) begin
         issue(OP_STORE, REG_PERBUS, W_WORD, 8'h00);
         chk(st != 0, i == 5);
      end
      issue(OP_INT_EN, REG_RAM, W_WORD, 8'h00);
      chk({st != 0, int_allowed, cop0_status[0]}, 3'h0);
      step;
      chk({int_allowed, cop0_status[0]}, 2'h3);
      issue(OP_INT_DIS, REG_RAM, W_WORD, 8'h00);
      chk({st != 0, ia_take, int_allowed, cop0_status[0]}, 4'h1);
      step;
      chk(cop0_status, 8'h00);
      issue(OP_COP0_WR, REG_RAM, W_WORD, 8'hA5);
      chk({st != 0, cop0_status}, 9'h000);
      step;
      chk({int_allowed, cop0_status}, 9'h1A5);
      issue(OP_COP0_WR, REG_RAM, W_WORD, 8'h5A);
      chk({ia_take, cop0_status}, 9'h0A5);
      step;
      chk(cop0_status, 8'h5A);
      issue(OP_STANDBY, REG_RAM, W_WORD, 8'h00);
      chk({st != 0, standby_mode}, 2'h0);
      step;
      chk(standby_mode, 1'b1);
      @(negedge clk);
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      #1;
      chk(standby_mode, 1'b0);
      // a load waits until every buffered store has drained
      issue(OP_LOAD, REG_RAM, W_WORD, 8'h00);
      wait_done(0);
      chk(sd_cnt - s0, 6);
      give_verdict();
   end

   // -----------------------------------------------------------
   // watchdog against a hang
   // -----------------------------------------------------------
   initial begin
      #(5 * 30000);
      n_mismatch++;
      give_verdict();
   end
endmodule : bus_cycle_sync_pipeline_control_tb_top
`default_nettype wire
